// ==== logic/rcs_pkg.sv ====
// Package of constants and types for reference clock select and request
package rcs_pkg;

  // Clock rate and low-power clock timing
  localparam int unsigned MCLK_HZ         = 25_000_000;
  localparam int unsigned SLOW_HZ         = 32_768;
  localparam int unsigned SLOW_PERIOD_CYC = MCLK_HZ / SLOW_HZ;
  localparam int unsigned SLOW_TOL_CYC    = 4;
  localparam int unsigned SLOW_MIN_CYC    = SLOW_PERIOD_CYC - SLOW_TOL_CYC;
  localparam int unsigned SLOW_MAX_CYC    = SLOW_PERIOD_CYC + SLOW_TOL_CYC;
  localparam int unsigned SLOW_STABLE_PER = 4;
  localparam int unsigned DET_PERIODS     = 64;
  localparam int unsigned REF_TICK_DIV    = 16;
  localparam int unsigned DET_CNT_TOL     = 3;

  // Frequency limits and defaults in Hz; trim step and range in ppm
  localparam logic [25:0] FREQ_DEFAULT_HZ = 26'd20_000_000;
  localparam logic [25:0] FREQ_MIN_HZ     = 26'd12_000_000;
  localparam logic [25:0] FREQ_MAX_HZ     = 26'd52_000_000;
  localparam int unsigned TRIM_STEP_PPM   = 2;
  localparam int unsigned TRIM_RANGE_PPM  = 50;
  localparam logic signed [7:0] TRIM_MAX_STEPS =
    8'(TRIM_RANGE_PPM / TRIM_STEP_PPM);

  localparam int unsigned STD_NUM = 17;

  // Standard reference frequencies
  localparam logic [25:0] STD_FREQ_HZ [STD_NUM] = '{
    26'd12_000_000, 26'd13_000_000, 26'd14_400_000, 26'd15_360_000,
    26'd16_200_000, 26'd16_800_000, 26'd18_000_000, 26'd19_200_000,
    26'd19_440_000, 26'd19_680_000, 26'd19_800_000, 26'd20_000_000,
    26'd24_000_000, 26'd26_000_000, 26'd33_600_000, 26'd37_400_000,
    26'd38_400_000
  };

  // Expected divided-reference ticks over DET_PERIODS low-power periods
  localparam logic [12:0] STD_DET_CNT [STD_NUM] = '{
    13'd1465, 13'd1587, 13'd1758, 13'd1875, 13'd1978, 13'd2051,
    13'd2197, 13'd2344, 13'd2373, 13'd2402, 13'd2417, 13'd2441,
    13'd2930, 13'd3174, 13'd4102, 13'd4565, 13'd4688
  };

  // Where the reference setting came from
  typedef enum logic [1:0] {
    RCS_SRC_DEFAULT = 2'h0,
    RCS_SRC_CONFIG  = 2'h1,
    RCS_SRC_DETECT  = 2'h2
  } rcs_src_e;

  // Power-on selection sequence
  typedef enum logic [3:0] {
    RCS_ST_CFG_WAIT = 4'h1,
    RCS_ST_OSC_CHK  = 4'h2,
    RCS_ST_MEASURE  = 4'h4,
    RCS_ST_DONE     = 4'h8
  } rcs_state_e;

  // Settings delivered by the config_memory loader
  typedef struct packed {
    logic               freq_present;
    logic [25:0]        freq_hz;
    logic               trim_present;
    logic signed [7:0]  trim_steps;
  } rcs_cfg_s;

endpackage

// ==== logic/rcs_clk_ctrl.sv ====
// Reference clock selection at power-on and clock request pin logic
//
// How it works
// - Request asserted awake, deasserted in sleep
// - Request is active high
// - Sleep timing uses low-power clock source
// - Request pin reassignable to general-purpose use
// - OR option: system request OR internal state
// - OR path combinational, independent of core
// - Default reference frequency is 20 MHz
// - Load frequency and trim from config memory
// - Auto-detect only with stable low-power clock
// - Detect only the seventeen standard frequencies
// - Detect needs 50/250 ppm source accuracy
// - Programmed frequency accepted from 12 to 52 MHz
// - Trim corrects up to plus/minus 50 ppm
// - Link and audio timing use configured frequency
`timescale 1ns/1ps

module rcs_clk_ctrl #(
  parameter int unsigned DET_PERIODS = rcs_pkg::DET_PERIODS
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic               clk_en_i,
  input  wire logic               cfg_done_i,
  input  wire rcs_pkg::rcs_cfg_s  cfg_i,
  input  wire logic               low_power_oscillator_i,
  input  wire logic               ref_tick_i,
  input  wire logic               awake_i,
  input  wire logic               or_mode_i,
  input  wire logic               sys_req_i,
  input  wire logic               pin_clkreq_sel_i,
  input  wire logic               pin_gpio_out_i,
  input  wire logic               pin_gpio_oe_n_i,
  output logic                    clk_req_pin_o,
  output logic                    clk_req_pin_oe_n_o,
  output logic                    lp_timebase_o,
  output logic                    low_power_oscillator_ok_o,
  output logic [25:0]             ref_freq_hz_o,
  output logic signed [7:0]       trim_steps_o,
  output rcs_pkg::rcs_src_e       freq_src_o,
  output logic                    freq_ready_o
);

  localparam logic [10:0] PER_MIN = 11'(rcs_pkg::SLOW_MIN_CYC);
  localparam logic [10:0] PER_MAX = 11'(rcs_pkg::SLOW_MAX_CYC);
  localparam logic [6:0]  DET_N   = 7'(DET_PERIODS);
  localparam logic [2:0]  STABLE_N = 3'(rcs_pkg::SLOW_STABLE_PER);
  localparam logic [12:0] CNT_TOL = 13'(rcs_pkg::DET_CNT_TOL);

  logic [1:0]              rst_sync_q;
  logic                    rst_n;
  rcs_pkg::rcs_state_e     state_q;
  logic                    lp_osc_prev_q;
  logic                    lp_osc_rise;
  logic [10:0]             per_cnt_q;
  logic                    per_good;
  logic                    per_late;
  logic [2:0]              stable_q;
  logic [6:0]              det_per_q;
  logic [12:0]             tick_cnt_q;
  logic                    req_q;
  logic                    or_mode_q;
  logic                    pin_sel_q;
  logic                    gpio_out_q;
  logic                    gpio_oe_n_q;
  logic [rcs_pkg::STD_NUM-1:0] hit;
  logic                    any_hit;
  logic [25:0]             hit_freq;
  logic                    cfg_freq_ok;
  logic signed [7:0]       trim_clamped;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Low-power clock period checker
  assign lp_osc_rise = low_power_oscillator_i & ~lp_osc_prev_q;
  assign per_good = lp_osc_rise && per_cnt_q >= PER_MIN
                    && per_cnt_q <= PER_MAX;
  assign per_late = per_cnt_q > PER_MAX;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lp_osc_prev_q <= 1'b0;
      per_cnt_q     <= 11'h0;
    end
    else if (clk_en_i)
    begin
      lp_osc_prev_q <= low_power_oscillator_i;
      if (lp_osc_rise)
        per_cnt_q <= 11'h1;
      else if (!per_late)
        per_cnt_q <= per_cnt_q + 11'h1;
    end
  end

  // Standard table match, one comparator per entry
  genvar gi;
  generate
    for (gi = 0; gi < rcs_pkg::STD_NUM; gi++)
    begin : g_match
      assign hit[gi] =
        (tick_cnt_q + CNT_TOL >= rcs_pkg::STD_DET_CNT[gi]) &&
        (tick_cnt_q <= rcs_pkg::STD_DET_CNT[gi] + CNT_TOL);
    end
  endgenerate

  always_comb
  begin
    any_hit  = 1'b0;
    hit_freq = rcs_pkg::FREQ_DEFAULT_HZ;
    for (int i = 0; i < rcs_pkg::STD_NUM; i++)
    begin
      if (hit[i] && !any_hit)
      begin
        any_hit  = 1'b1;
        hit_freq = rcs_pkg::STD_FREQ_HZ[i];
      end
    end
  end

  // Config frequency outside the range is treated as absent
  assign cfg_freq_ok = cfg_i.freq_present
                       && cfg_i.freq_hz >= rcs_pkg::FREQ_MIN_HZ
                       && cfg_i.freq_hz <= rcs_pkg::FREQ_MAX_HZ;

  always_comb
  begin
    if (cfg_i.trim_steps > rcs_pkg::TRIM_MAX_STEPS)
      trim_clamped = rcs_pkg::TRIM_MAX_STEPS;
    else if (cfg_i.trim_steps < -rcs_pkg::TRIM_MAX_STEPS)
      trim_clamped = -rcs_pkg::TRIM_MAX_STEPS;
    else
      trim_clamped = cfg_i.trim_steps;
  end

  // Power-on selection sequence
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q       <= rcs_pkg::RCS_ST_CFG_WAIT;
      stable_q      <= 3'h0;
      det_per_q     <= 7'h0;
      tick_cnt_q    <= 13'h0;
      ref_freq_hz_o <= rcs_pkg::FREQ_DEFAULT_HZ;
      trim_steps_o  <= 8'sh0;
      freq_src_o    <= rcs_pkg::RCS_SRC_DEFAULT;
      freq_ready_o  <= 1'b0;
      low_power_oscillator_ok_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      unique case (state_q)
        rcs_pkg::RCS_ST_CFG_WAIT:
        begin
          if (cfg_done_i)
          begin
            if (cfg_i.trim_present)
              trim_steps_o <= trim_clamped;
            if (cfg_freq_ok)
            begin
              ref_freq_hz_o <= cfg_i.freq_hz;
              freq_src_o    <= rcs_pkg::RCS_SRC_CONFIG;
              state_q       <= rcs_pkg::RCS_ST_DONE;
            end
            else
              state_q <= rcs_pkg::RCS_ST_OSC_CHK;
          end
        end
        rcs_pkg::RCS_ST_OSC_CHK:
        begin
          // Needs several clean periods in a row before trusting it
          if (per_late || (lp_osc_rise && !per_good))
          begin
            stable_q <= 3'h0;
            if (per_late)
              state_q <= rcs_pkg::RCS_ST_DONE;
          end
          else if (per_good)
          begin
            if (stable_q == STABLE_N - 3'h1)
            begin
              low_power_oscillator_ok_o <= 1'b1;
              det_per_q    <= 7'h0;
              tick_cnt_q   <= 13'h0;
              state_q      <= rcs_pkg::RCS_ST_MEASURE;
            end
            else
              stable_q <= stable_q + 3'h1;
          end
        end
        rcs_pkg::RCS_ST_MEASURE:
        begin
          if (ref_tick_i && tick_cnt_q != 13'h1fff)
            tick_cnt_q <= tick_cnt_q + 13'h1;
          if (per_late || (lp_osc_rise && !per_good))
          begin
            // Unstable low-power clock: detection result not trusted
            low_power_oscillator_ok_o <= 1'b0;
            state_q      <= rcs_pkg::RCS_ST_DONE;
          end
          else if (per_good)
          begin
            if (det_per_q == DET_N - 7'h1)
            begin
              if (any_hit)
              begin
                ref_freq_hz_o <= hit_freq;
                freq_src_o    <= rcs_pkg::RCS_SRC_DETECT;
              end
              state_q <= rcs_pkg::RCS_ST_DONE;
            end
            else
              det_per_q <= det_per_q + 7'h1;
          end
        end
        rcs_pkg::RCS_ST_DONE:
        begin
          // Consumers time their bits from this value only once ready
          freq_ready_o <= 1'b1;
          if (low_power_oscillator_ok_o && per_late)
            low_power_oscillator_ok_o <= 1'b0;
          else if (per_good)
            low_power_oscillator_ok_o <= 1'b1;
        end
        default:
          state_q <= rcs_pkg::RCS_ST_CFG_WAIT;
      endcase
    end
  end

  // Awake/sleep state and sleep timebase
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_q         <= 1'b1;
      lp_timebase_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      req_q         <= awake_i;
      lp_timebase_o <= ~awake_i;
    end
  end

  // Pin function selection
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      or_mode_q   <= 1'b0;
      pin_sel_q   <= 1'b1;
      gpio_out_q  <= 1'b0;
      gpio_oe_n_q <= 1'b1;
    end
    else if (clk_en_i)
    begin
      or_mode_q   <= or_mode_i;
      pin_sel_q   <= pin_clkreq_sel_i;
      gpio_out_q  <= pin_gpio_out_i;
      gpio_oe_n_q <= pin_gpio_oe_n_i;
    end
  end

  // The OR path is left combinational so a system request still reaches
  // the oscillator with the clock stopped or frozen
  always_comb
  begin
    if (!pin_sel_q)
    begin
      clk_req_pin_o      = gpio_out_q;
      clk_req_pin_oe_n_o = gpio_oe_n_q;
    end
    else
    begin
      // Relies on the system driving sys_req_i to a defined level
      clk_req_pin_o      = req_q | (or_mode_q & sys_req_i);
      clk_req_pin_oe_n_o = 1'b0;
    end
  end

endmodule

// ==== dv/rcs_clk_ctrl_props.sv ====
// Checker for reference clock selection and request pin
`timescale 1ns/1ps
module rcs_clk_ctrl_props (
  input wire logic              mclk_i,
  input wire logic              rst_n_i,
  input wire logic              clk_en_i,
  input wire logic              cfg_done_i,
  input wire rcs_pkg::rcs_cfg_s cfg_i,
  input wire logic              awake_i,
  input wire logic              or_mode_i,
  input wire logic              sys_req_i,
  input wire logic              pin_clkreq_sel_i,
  input wire logic              pin_gpio_out_i,
  input wire logic              clk_req_pin_o,
  input wire logic              clk_req_pin_oe_n_o,
  input wire logic              lp_timebase_o,
  input wire logic [25:0]       ref_freq_hz_o,
  input wire logic signed [7:0] trim_steps_o,
  input wire rcs_pkg::rcs_src_e freq_src_o,
  input wire logic              freq_ready_o
);
  logic [1:0] up_q;
  logic       live;
  logic       rst_seen_q;
  // Inputs first land at the third edge after release
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  assign live = (up_q == 2'h3);
  // First edge in reset still sees unsettled outputs; checked from the next
  always_ff @(posedge mclk_i)
    rst_seen_q <= !rst_n_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence cfg_take_s;
    live && clk_en_i && cfg_done_i && !freq_ready_o && cfg_i.freq_present
      && cfg_i.freq_hz inside {[rcs_pkg::FREQ_MIN_HZ:rcs_pkg::FREQ_MAX_HZ]};
  endsequence
  sequence cfg_set_s;
    (ref_freq_hz_o == $past(cfg_i.freq_hz)
      && freq_src_o == rcs_pkg::RCS_SRC_CONFIG) ##1 freq_ready_o;
  endsequence
  cfg_load_a: assert property (
    cfg_take_s |=> cfg_set_s) else $error("config frequency not loaded");
  or_comb_a: assert property (
    live && $past(clk_en_i && pin_clkreq_sel_i && or_mode_i) && sys_req_i
      |-> clk_req_pin_o) else $error("system request not passed");
  req_awake_a: assert property (
    live && $past(clk_en_i && pin_clkreq_sel_i && !or_mode_i)
      |-> clk_req_pin_o == $past(awake_i) && !clk_req_pin_oe_n_o)
    else $error("request does not follow awake");
  gpio_mode_a: assert property (
    live && $past(clk_en_i && !pin_clkreq_sel_i)
      |-> clk_req_pin_o == $past(pin_gpio_out_i))
    else $error("pin not general purpose");
  sleep_lp_a: assert property (
    live && $past(clk_en_i) |-> lp_timebase_o == !$past(awake_i))
    else $error("sleep timebase wrong");
  reset_def_a: assert property (disable iff (1'b0)
    rst_seen_q && !rst_n_i |-> clk_req_pin_o && !clk_req_pin_oe_n_o
      && !freq_ready_o && ref_freq_hz_o == rcs_pkg::FREQ_DEFAULT_HZ)
    else $error("reset state wrong");
  ready_hold_a: assert property (
    freq_ready_o |=> freq_ready_o && $stable(ref_freq_hz_o)
      && $stable(freq_src_o)) else $error("selection changed");
  cfg_range_a: assert property (
    freq_src_o == rcs_pkg::RCS_SRC_CONFIG |-> ref_freq_hz_o inside
      {[rcs_pkg::FREQ_MIN_HZ:rcs_pkg::FREQ_MAX_HZ]})
    else $error("config frequency out of range");
  trim_clamp_a: assert property (
    trim_steps_o <= rcs_pkg::TRIM_MAX_STEPS
      && trim_steps_o >= -rcs_pkg::TRIM_MAX_STEPS)
    else $error("trim beyond range");
endmodule

// ==== dv/rcs_osc_model.sv ====
// Behavioural reference and low-power oscillators
`timescale 1ns/1ps
module rcs_osc_model #(
  parameter int unsigned REF_HZ = rcs_pkg::STD_FREQ_HZ[13]
) (
  input  wire logic mclk_i,
  input  wire logic run_i,
  output logic      lp_osc_o = 1'b0,
  output logic      ref_tick_o = 1'b0
);
  int unsigned lacc = 0;
  int unsigned racc = 0;
  // Accumulators keep both rates exact, well inside detection accuracy
  always @(posedge mclk_i)
  begin
    ref_tick_o <= 1'b0;
    racc = racc + REF_HZ / rcs_pkg::REF_TICK_DIV;
    if (racc >= rcs_pkg::MCLK_HZ)
    begin
      racc = racc - rcs_pkg::MCLK_HZ;
      ref_tick_o <= 1'b1;
    end
    // Absent clock stands still low
    lacc = run_i ? lacc + 2 * rcs_pkg::SLOW_HZ : 0;
    if (!run_i)
      lp_osc_o <= 1'b0;
    else if (lacc >= rcs_pkg::MCLK_HZ)
    begin
      lacc = lacc - rcs_pkg::MCLK_HZ;
      lp_osc_o <= !lp_osc_o;
    end
  end
endmodule

// ==== dv/test_reference_clock_select_and_request.sv ====
// Self-checking bench for reference clock selection and request
`timescale 1ns/1ps
bind rcs_clk_ctrl rcs_clk_ctrl_props u_props (.*);
module test_reference_clock_select_and_request;
  localparam logic [25:0] F26 = rcs_pkg::STD_FREQ_HZ[13];
  localparam logic [25:0] FMIN = rcs_pkg::FREQ_MIN_HZ;
  localparam logic [25:0] FMAX = rcs_pkg::FREQ_MAX_HZ;
  localparam logic [25:0] FDEF = rcs_pkg::FREQ_DEFAULT_HZ;
  typedef struct packed {
    rcs_pkg::rcs_cfg_s cfg;
    logic              osc;
    logic [25:0]       freq;
    logic [1:0]        src;
    logic [7:0]        trim;
  } rcs_row_s;
  logic              mclk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              clk_en_i = 1'b1;
  logic              cfg_done_i = 1'b1;
  rcs_pkg::rcs_cfg_s cfg_i = '0;
  logic              osc_run = 1'b0;
  logic              low_power_oscillator_i;
  logic              ref_tick_i;
  logic              awake_i = 1'b1;
  logic              or_mode_i = 1'b0;
  logic              sys_req_i = 1'b0;
  logic              pin_clkreq_sel_i = 1'b1;
  logic              pin_gpio_out_i = 1'b0;
  logic              pin_gpio_oe_n_i = 1'b1;
  logic              clk_req_pin_o;
  logic              clk_req_pin_oe_n_o;
  logic              lp_timebase_o;
  logic              low_power_oscillator_ok_o;
  logic [25:0]       ref_freq_hz_o;
  logic signed [7:0] trim_steps_o;
  rcs_pkg::rcs_src_e freq_src_o;
  logic              freq_ready_o;
  int                fail_count = 0;
  int                checks_done = 0;
  rcs_row_s          rows [5] = '{
    '{'{1'b1, F26, 1'b1, 8'h05}, 1'b0, F26, 2'h1, 8'h05},
    '{'{1'b1, FMAX + 26'h1, 1'b1, 8'h28}, 1'b0, FDEF, 2'h0, 8'h19},
    '{'{1'b1, FMIN, 1'b1, 8'he2}, 1'b0, FMIN, 2'h1, 8'he7},
    '{'{1'b1, FMAX, 1'b0, 8'h10}, 1'b0, FMAX, 2'h1, 8'h00},
    '{'{1'b0, F26, 1'b0, 8'h00}, 1'b1, F26, 2'h2, 8'h00}
  };

  always #20 mclk_i = ~mclk_i;

  rcs_clk_ctrl DUT (.*);
  rcs_osc_model u_osc (
    .mclk_i     (mclk_i),
    .run_i      (osc_run),
    .lp_osc_o   (low_power_oscillator_i),
    .ref_tick_o (ref_tick_i)
  );

  task automatic check(input logic [25:0] got, input logic [25:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge mclk_i);
    #2;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One detection run takes about 52300 cycles; the rest are short
  initial
  begin
    repeat (80000) @(posedge mclk_i);
    fail_count++;
    results();
  end

  initial
  begin
    foreach (rows[i])
    begin
      rst_n_i = 1'b0;
      cfg_i = rows[i].cfg;
      osc_run = rows[i].osc;
      repeat (4) step();
      rst_n_i = 1'b1;
      for (int n = 0; n < 60000 && freq_ready_o !== 1'b1; n++)
        step();
      check(freq_ready_o, 1'b1);
      check(ref_freq_hz_o, rows[i].freq);
      check(freq_src_o, rows[i].src);
      check({trim_steps_o}, rows[i].trim);
      check(low_power_oscillator_ok_o, rows[i].osc);
      $display("row %0d done", i);
    end
    rst_n_i = 1'b0;
    cfg_i = '0;
    osc_run = 1'b0;
    step();
    check(clk_req_pin_o, 1'b1);
    check(ref_freq_hz_o, FDEF);
    rst_n_i = 1'b1;
    repeat (4) step();
    or_mode_i = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      awake_i = k[1];
      step();
      sys_req_i = k[0];
      #1;
      check(clk_req_pin_o, k[1] | k[0]);
      check(lp_timebase_o, !k[1]);
      step();
    end
    or_mode_i = 1'b0;
    awake_i = 1'b0;
    step();
    check(clk_req_pin_o, 1'b0);
    check(clk_req_pin_oe_n_o, 1'b0);
    pin_clkreq_sel_i = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      pin_gpio_out_i = k[0];
      pin_gpio_oe_n_i = !k[0];
      step();
      check(clk_req_pin_o, k[0]);
      check(clk_req_pin_oe_n_o, !k[0]);
    end
    $display("request test done");
    // Enable low: pin and timebase must keep their last values
    clk_en_i = 1'b0;
    pin_gpio_out_i = 1'b0;
    awake_i = 1'b1;
    step();
    check(clk_req_pin_o, 1'b1);
    check(lp_timebase_o, 1'b1);
    clk_en_i = 1'b1;
    step();
    check(clk_req_pin_o, 1'b0);
    check(lp_timebase_o, 1'b0);
    $display("enable test done");
    results();
  end
endmodule
